// *** motion_detect_pkg.sv ***
// constants, state layout and carrier types for the motion event detection block
package motion_detect_pkg;

  // time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_MS_NS = 500000;
  localparam int HALF_MS_CYCLES = (HALF_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W = 20;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_SOURCE = 6'h0A;
  localparam logic [5:0] IDX_MODE = 6'h16;
  localparam logic [5:0] IDX_CLEAR = 6'h17;
  localparam logic [5:0] IDX_CTRL_A = 6'h18;
  localparam logic [5:0] IDX_CTRL_B = 6'h19;
  localparam logic [5:0] IDX_LEVEL_LIM = 6'h1A;
  localparam logic [5:0] IDX_PULSE_LIM = 6'h1B;
  localparam logic [5:0] IDX_PULSE_LEN = 6'h1C;
  localparam logic [5:0] IDX_PULSE_GAP = 6'h1D;
  localparam logic [5:0] IDX_SPAN = 6'h1E;

  // field positions
  localparam int CLR_A_BIT = 0;
  localparam int CLR_B_BIT = 1;
  localparam int PIN_SWAP_BIT = 0;
  localparam int SRC_LSB = 1;
  localparam int AXIS_DIS_LSB = 3;
  localparam int THRESHOLD_SIGNED_OPTION_BIT = 6;
  localparam int FILTER_BANDWIDTH_SELECT_BIT = 7;
  localparam int LEVEL_POLARITY_COMBINE_BIT = 0;
  localparam int PULSE_POLARITY_COMBINE_BIT = 1;
  localparam int OUTPUT_DRIVE_STRENGTH_BIT = 2;

  localparam logic [7:0] REG_RESET = 8'h00;

  // operating modes
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_MEASURE = 2'h1;
  localparam logic [1:0] MODE_LEVEL = 2'h2;
  localparam logic [1:0] MODE_PULSE = 2'h3;

  // interrupt source routing
  localparam logic [1:0] SRC_LEVEL_PULSE = 2'h0;
  localparam logic [1:0] SRC_PULSE_LEVEL = 2'h1;
  localparam logic [1:0] SRC_SINGLE_DOUBLE = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0][7:0] axis;
  } sample_t;

  typedef enum logic [2:0] {P_IDLE, P_FIRST, P_LATENCY, P_WINDOW, P_SECOND, P_RELEASE} pulse_state_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] clear;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] level_lim;
    logic [7:0] pulse_lim;
    logic [7:0] pulse_len;
    logic [7:0] pulse_gap;
    logic [7:0] span;
    logic [2:0] level_flags;
    logic [2:0] pulse_flags;
    logic [2:0] pulse_axes;
    logic flag_a;
    logic flag_b;
    logic line_a;
    logic line_b;
    pulse_state_t pstate;
    logic [8:0] timer;
    logic [DIV_W-1:0] div;
    logic half_tick;
    logic awready;
    logic aw_held;
    logic [5:0] aw_idx;
    logic wready;
    logic w_held;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } state_t;

endpackage

// *** motion_event_detect_config.sv ***
// motion event detection with its control registers on an AXI4-Lite slave
//
// What this block does
// R1: mode field selects standby, measure, level, pulse
// R2: clear bit A drops line A and flags
// R3: zero in clear bit A changes nothing
// R4: clear bit B drops line B and flags
// R5: zero in clear bit B changes nothing
// R6: source 00: A level, B pulse
// R7: source 01: A pulse, B level
// R8: source 10: A single, B single or double
// R9: swap bit exchanges the two interrupt pins
// R10: axis disable bits exclude axes from detection
// R11: threshold option: absolute or signed level compare
// R12: bandwidth bit selects 62.5 Hz or 125 Hz
// R13: level polarity: positive OR, negative AND
// R14: pulse polarity: positive OR, negative AND
// R15: level limit unsigned 7-bit or signed 8-bit
// R16: pulse limit uses low seven bits only
// R17: host writes zero to pulse limit top bit
// R18: pulse length counts in 0.5 ms steps
// R19: pulse gap counts in 1 ms steps
// R20: second pulse span counts in 1 ms steps
// R21: all these registers reset to zero
// R22: flags and lines stay latched until cleared
// R23: timers run from a fixed derived time base
//
// The AXI4-Lite register port was chosen for this implementation.
module motion_event_detect_config #(
  parameter int ADDR_W = 8,
  parameter int TICK_CYCLES = motion_detect_pkg::HALF_MS_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire motion_detect_pkg::sample_t SAMPLE,
  input wire logic SAMPLE_VALID,
  output logic IRQ_LINE_A,
  output logic IRQ_LINE_B,
  output logic FILTER_BW_SEL,
  output logic OUTPUT_DRIVE_STRONG,
  output logic [1:0] OPERATING_MODE
);

  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end
  if (TICK_CYCLES < 2 || TICK_CYCLES > 2 ** motion_detect_pkg::DIV_W) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  motion_detect_pkg::state_t s;
  motion_detect_pkg::state_t n;

  logic [2:0] axis_en;
  logic [2:0] lvl_hit;
  logic [2:0] pls_hit;
  logic level_any;
  logic pulse_any;

  // per-axis compare against the level and pulse limits
  for (genvar i = 0; i < 3; i++) begin : g_axis
    logic [7:0] v;
    logic [7:0] mag;
    logic lvl_above;
    logic pls_above;
    assign v = SAMPLE.axis[i];
    assign mag = v[7] ? 8'(-v) : v;
    // R10: axis disable
    assign axis_en[i] = !s.ctrl_a[motion_detect_pkg::AXIS_DIS_LSB + i];
    // R11: R15: absolute or signed compare
    assign lvl_above = s.ctrl_a[motion_detect_pkg::THRESHOLD_SIGNED_OPTION_BIT] ? ($signed(v) >= $signed(s.level_lim))
                                                                : (mag >= {1'b0, s.level_lim[6:0]});
    // R16: low seven bits only
    assign pls_above = mag >= {1'b0, s.pulse_lim[6:0]};
    assign lvl_hit[i] = s.ctrl_b[motion_detect_pkg::LEVEL_POLARITY_COMBINE_BIT] ? !lvl_above : lvl_above;
    assign pls_hit[i] = s.ctrl_b[motion_detect_pkg::PULSE_POLARITY_COMBINE_BIT] ? !pls_above : pls_above;
  end

  // R13: level combine across axes
  assign level_any = s.ctrl_b[motion_detect_pkg::LEVEL_POLARITY_COMBINE_BIT] ? ((&(lvl_hit | ~axis_en)) && (|axis_en))
                                                           : (|(lvl_hit & axis_en));
  // R14: pulse combine across axes
  assign pulse_any = s.ctrl_b[motion_detect_pkg::PULSE_POLARITY_COMBINE_BIT] ? ((&(pls_hit | ~axis_en)) && (|axis_en))
                                                           : (|(pls_hit & axis_en));

  always_comb begin
    logic wr_fire;
    logic [5:0] ar_idx;
    logic level_ev;
    logic single_ev;
    logic double_ev;
    logic ev_a;
    logic ev_b;
    logic a_is_level;
    logic b_is_level;
    logic clr_a;
    logic clr_b;
    logic [1:0] src;
    logic double_sel;
    logic [8:0] len_half;
    logic [8:0] gap_half;
    logic [8:0] span_half;
    n = s;
    ev_a = 1'b0;
    ev_b = 1'b0;
    a_is_level = 1'b0;
    b_is_level = 1'b0;
    clr_a = 1'b0;
    clr_b = 1'b0;
    double_sel = 1'b0;
    wr_fire = 1'b0;
    ar_idx = ARADDR[7:2];
    level_ev = 1'b0;
    single_ev = 1'b0;
    double_ev = 1'b0;
    src = s.ctrl_a[motion_detect_pkg::SRC_LSB +: 2];
    // R18: duration in half-millisecond ticks
    len_half = {1'b0, s.pulse_len};
    // R19: latency in whole milliseconds
    gap_half = {s.pulse_gap, 1'b0};
    // R20: second window in whole milliseconds
    span_half = {s.span, 1'b0};

    // R23: half-millisecond tick divider
    n.half_tick = 1'b0;
    if (s.div == motion_detect_pkg::DIV_W'(TICK_CYCLES - 1)) begin
      n.div = '0;
      n.half_tick = 1'b1;
    end else begin
      n.div = s.div + 1'b1;
    end

    // write address and data are taken independently
    if (AWVALID && s.awready) begin
      n.aw_held = 1'b1;
      n.aw_idx = AWADDR[7:2];
    end
    if (WVALID && s.wready) begin
      n.w_held = 1'b1;
      n.wdata = WDATA[7:0];
      n.wstrb0 = WSTRB[0];
    end
    if (s.bvalid && BREADY) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      wr_fire = s.wstrb0;
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = motion_detect_pkg::RESP_OKAY;
      case (s.aw_idx)
        motion_detect_pkg::IDX_SOURCE: begin
          wr_fire = 1'b0;
        end
        motion_detect_pkg::IDX_MODE,
        motion_detect_pkg::IDX_CLEAR,
        motion_detect_pkg::IDX_CTRL_A,
        motion_detect_pkg::IDX_CTRL_B,
        motion_detect_pkg::IDX_LEVEL_LIM,
        motion_detect_pkg::IDX_PULSE_LIM,
        motion_detect_pkg::IDX_PULSE_LEN,
        motion_detect_pkg::IDX_PULSE_GAP,
        motion_detect_pkg::IDX_SPAN: begin
        end
        default: begin
          wr_fire = 1'b0;
          n.bresp = motion_detect_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (wr_fire) begin
      case (s.aw_idx)
        motion_detect_pkg::IDX_MODE: n.mode = s.wdata[1:0];
        motion_detect_pkg::IDX_CLEAR: n.clear = s.wdata;
        motion_detect_pkg::IDX_CTRL_A: n.ctrl_a = s.wdata;
        motion_detect_pkg::IDX_CTRL_B: n.ctrl_b = {5'h00, s.wdata[2:0]};
        motion_detect_pkg::IDX_LEVEL_LIM: n.level_lim = s.wdata;
        motion_detect_pkg::IDX_PULSE_LIM: n.pulse_lim = s.wdata;
        motion_detect_pkg::IDX_PULSE_LEN: n.pulse_len = s.wdata;
        motion_detect_pkg::IDX_PULSE_GAP: n.pulse_gap = s.wdata;
        motion_detect_pkg::IDX_SPAN: n.span = s.wdata;
        default: n.mode = s.mode;
      endcase
    end
    // R2: R3: R4: R5: clear acts only on a written one
    clr_a = wr_fire && (s.aw_idx == motion_detect_pkg::IDX_CLEAR) && s.wdata[motion_detect_pkg::CLR_A_BIT];
    clr_b = wr_fire && (s.aw_idx == motion_detect_pkg::IDX_CLEAR) && s.wdata[motion_detect_pkg::CLR_B_BIT];

    // read channel
    if (s.rvalid && RREADY) begin
      n.rvalid = 1'b0;
    end
    if (ARVALID && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp = motion_detect_pkg::RESP_OKAY;
      case (ar_idx)
        motion_detect_pkg::IDX_SOURCE: n.rdata = {s.flag_b, s.flag_a, s.pulse_flags, s.level_flags};
        motion_detect_pkg::IDX_MODE: n.rdata = {6'h00, s.mode};
        motion_detect_pkg::IDX_CLEAR: n.rdata = s.clear;
        motion_detect_pkg::IDX_CTRL_A: n.rdata = s.ctrl_a;
        motion_detect_pkg::IDX_CTRL_B: n.rdata = s.ctrl_b;
        motion_detect_pkg::IDX_LEVEL_LIM: n.rdata = s.level_lim;
        motion_detect_pkg::IDX_PULSE_LIM: n.rdata = s.pulse_lim;
        motion_detect_pkg::IDX_PULSE_LEN: n.rdata = s.pulse_len;
        motion_detect_pkg::IDX_PULSE_GAP: n.rdata = s.pulse_gap;
        motion_detect_pkg::IDX_SPAN: n.rdata = s.span;
        default: begin
          n.rdata = 8'h00;
          n.rresp = motion_detect_pkg::RESP_SLVERR;
        end
      endcase
    end

    // R1: level detection runs in level mode only
    level_ev = SAMPLE_VALID && level_any && (s.mode == motion_detect_pkg::MODE_LEVEL);

    // pulse timing; hit changes are judged on samples, time on ticks
    if (s.half_tick && s.timer != 9'h1FF) begin
      n.timer = s.timer + 1'b1;
    end
    case (s.pstate)
      motion_detect_pkg::P_IDLE: begin
        if (SAMPLE_VALID && pulse_any) begin
          n.pulse_axes = pls_hit & axis_en;
          n.timer = '0;
          n.pstate = motion_detect_pkg::P_FIRST;
        end
      end
      motion_detect_pkg::P_FIRST: begin
        // R18: too long a pulse is no pulse
        if (s.timer > len_half) begin
          n.pstate = motion_detect_pkg::P_RELEASE;
        end else if (SAMPLE_VALID && !pulse_any) begin
          single_ev = 1'b1;
          n.timer = '0;
          n.pstate = motion_detect_pkg::P_LATENCY;
        end
      end
      motion_detect_pkg::P_LATENCY: begin
        // R19: dead time before the second window
        if (s.timer >= gap_half) begin
          n.timer = '0;
          n.pstate = motion_detect_pkg::P_WINDOW;
        end
      end
      motion_detect_pkg::P_WINDOW: begin
        // R20: second pulse must start inside the window
        if (s.timer >= span_half) begin
          n.pstate = motion_detect_pkg::P_IDLE;
        end else if (SAMPLE_VALID && pulse_any) begin
          n.pulse_axes = s.pulse_axes | (pls_hit & axis_en);
          n.timer = '0;
          n.pstate = motion_detect_pkg::P_SECOND;
        end
      end
      motion_detect_pkg::P_SECOND: begin
        if (s.timer > len_half) begin
          n.pstate = motion_detect_pkg::P_RELEASE;
        end else if (SAMPLE_VALID && !pulse_any) begin
          double_ev = 1'b1;
          n.pstate = motion_detect_pkg::P_IDLE;
        end
      end
      motion_detect_pkg::P_RELEASE: begin
        if (SAMPLE_VALID && !pulse_any) begin
          n.pstate = motion_detect_pkg::P_IDLE;
        end
      end
      default: n.pstate = motion_detect_pkg::P_IDLE;
    endcase
    // R1: pulse detection runs in pulse mode only
    if (s.mode != motion_detect_pkg::MODE_PULSE) begin
      n.pstate = motion_detect_pkg::P_IDLE;
      single_ev = 1'b0;
      double_ev = 1'b0;
    end

    // R6: R7: R8: route events to the two flags
    double_sel = (s.span != 8'h00) && (s.pulse_gap != 8'h00);
    case (src)
      motion_detect_pkg::SRC_PULSE_LEVEL: begin
        ev_a = single_ev;
        ev_b = level_ev;
        a_is_level = 1'b0;
        b_is_level = 1'b1;
      end
      motion_detect_pkg::SRC_SINGLE_DOUBLE: begin
        ev_a = single_ev;
        ev_b = double_sel ? double_ev : single_ev;
        a_is_level = 1'b0;
        b_is_level = 1'b0;
      end
      default: begin
        ev_a = level_ev;
        ev_b = single_ev;
        a_is_level = 1'b1;
        b_is_level = 1'b0;
      end
    endcase

    // R22: latched flags, a new event wins over a clear
    n.flag_a = ev_a || (s.flag_a && !clr_a);
    n.flag_b = ev_b || (s.flag_b && !clr_b);
    if ((clr_a && a_is_level) || (clr_b && b_is_level)) begin
      n.level_flags = 3'h0;
    end
    if ((clr_a && !a_is_level) || (clr_b && !b_is_level)) begin
      n.pulse_flags = 3'h0;
    end
    if (level_ev) begin
      n.level_flags = n.level_flags | (lvl_hit & axis_en);
    end
    if (single_ev || double_ev) begin
      n.pulse_flags = n.pulse_flags | s.pulse_axes;
    end

    // R9: pin swap
    n.line_a = s.ctrl_a[motion_detect_pkg::PIN_SWAP_BIT] ? n.flag_b : n.flag_a;
    n.line_b = s.ctrl_a[motion_detect_pkg::PIN_SWAP_BIT] ? n.flag_a : n.flag_b;

    n.awready = !n.aw_held;
    n.wready = !n.w_held;
    n.arready = !n.rvalid;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      // R21: every register clears on reset
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign AWREADY = s.awready;
  assign WREADY = s.wready;
  assign BVALID = s.bvalid;
  assign BRESP = s.bresp;
  assign ARREADY = s.arready;
  assign RVALID = s.rvalid;
  assign RRESP = s.rresp;
  assign RDATA = {24'h000000, s.rdata};
  assign IRQ_LINE_A = s.line_a;
  assign IRQ_LINE_B = s.line_b;
  // R12: filter bandwidth select to the filter
  assign FILTER_BW_SEL = s.ctrl_a[motion_detect_pkg::FILTER_BANDWIDTH_SELECT_BIT];
  assign OUTPUT_DRIVE_STRONG = s.ctrl_b[motion_detect_pkg::OUTPUT_DRIVE_STRENGTH_BIT];
  assign OPERATING_MODE = s.mode;

endmodule

// *** sample_source.sv ***
// front end model that hands acceleration samples to the block
module sample_source (
  input wire logic clk,
  output motion_detect_pkg::sample_t sample,
  output logic sample_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sample = '0;
    sample_valid = 1'b0;
  end
  // one sample per call; the bus scrambles once the strobe drops
  task automatic emit(input logic [23:0] s);
    @(posedge clk);
    sample <= s;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample <= ~s;
    sample_valid <= 1'b0;
  endtask
endmodule

// *** motion_event_detect_config_assertions.sv ***
// port checks for the motion event detection block
module motion_detect_checker (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic IRQ_LINE_A,
  input wire logic IRQ_LINE_B,
  input wire logic FILTER_BW_SEL,
  input wire logic [1:0] OPERATING_MODE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_both_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_answer;
    ##2 BVALID;
  endsequence
  a_write_answer: assert property (s_both_taken |-> s_answer) else $error("write response not on time");
  a_bvalid_single: assert property (BVALID && BREADY |=> !BVALID) else $error("write response repeated");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID) else $error("read data not on time");
  a_rvalid_single: assert property (RVALID && RREADY |=> !RVALID) else $error("read data repeated");
  a_ar_blocked: assert property (RVALID |-> !ARREADY) else $error("read address taken while busy");
  a_upper_zero: assert property (RVALID |-> RDATA[31:8] == 24'h000000) else $error("read upper bits set");
  a_reset_quiet: assert property (disable iff (1'b0) !RST_N |=>
    !IRQ_LINE_A && !IRQ_LINE_B && !BVALID && !RVALID && OPERATING_MODE == 2'h0) else $error("outputs not clear");
  a_irq_latched: assert property ($fell(IRQ_LINE_A) || $fell(IRQ_LINE_B) |->
    BVALID || $past(BVALID) || !$past(RST_N)) else $error("interrupt dropped without write");
  a_config_by_write: assert property (!$stable(OPERATING_MODE) || !$stable(FILTER_BW_SEL) |->
    BVALID || !$past(RST_N)) else $error("setting changed without write");
endmodule

bind motion_event_detect_config motion_detect_checker u_checker (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
  .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .IRQ_LINE_A(IRQ_LINE_A), .IRQ_LINE_B(IRQ_LINE_B),
  .FILTER_BW_SEL(FILTER_BW_SEL), .OPERATING_MODE(OPERATING_MODE)
);

// *** motion_event_detect_config_tb.sv ***
// self-checking bench for the motion event detection block
module motion_event_detect_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
  logic clk;
  logic rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, irq_a, irq_b, bw_sel, drive_strong, sample_valid;
  logic [1:0] bresp, rresp, mode, wresp, rd_resp;
  logic [31:0] rdata, rd_data;
  motion_detect_pkg::sample_t sample;
  int n_mismatch = 0, n_compared = 0, cycles = 0;

  sample_source src (.clk(clk), .sample(sample), .sample_valid(sample_valid));
  motion_event_detect_config #(.ADDR_W(8), .TICK_CYCLES(4)) DUT (
    .CORE_CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .SAMPLE(sample), .SAMPLE_VALID(sample_valid),
    .IRQ_LINE_A(irq_a), .IRQ_LINE_B(irq_b), .FILTER_BW_SEL(bw_sel),
    .OUTPUT_DRIVE_STRONG(drive_strong), .OPERATING_MODE(mode)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    wresp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_data = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
    rd(idx);
    `CHK("register", {24'h000000, e}, rd_data)
  endtask

  task automatic irq_is(input logic ea, input logic eb);
    repeat (20) @(posedge clk);
    `CHK("line a", ea, irq_a)
    `CHK("line b", eb, irq_b)
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  initial begin
    rst_n <= 1'b0;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    awaddr <= 8'h00;
    araddr <= 8'h00;
    wdata <= 32'h00000000;
    wstrb <= 4'hF;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 23; i <= 30; i++) rchk(6'(i), 8'h00);
    rd(6'h00);
    `CHK("unmapped read", 2'h2, rd_resp)
    wr(6'h3F, 8'h55);
    `CHK("unmapped write", 2'h2, wresp)
    done("reset");
    // host keeps top bit of pulse limit at zero
    for (int i = 26; i <= 30; i++) begin
      wr(6'(i), 8'h35);
      rchk(6'(i), 8'h35);
    end
    // lane 0 strobe low: the write is answered but nothing is stored
    wstrb <= 4'h0;
    wr(6'h1A, 8'h77);
    wstrb <= 4'hF;
    `CHK("masked write", 2'h0, wresp)
    rchk(6'h1A, 8'h35);
    wr(motion_detect_pkg::IDX_SOURCE, 8'hFF);
    `CHK("source write", 2'h0, wresp)
    rchk(motion_detect_pkg::IDX_SOURCE, 8'h00);
    wr(6'h19, 8'hFF);
    rchk(6'h19, 8'h07);
    `CHK("drive", 1'b1, drive_strong)
    wr(6'h19, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(motion_detect_pkg::IDX_MODE, 8'(m));
      `CHK("mode", 2'(m), mode)
    end
    wr(6'h18, 8'h80);
    `CHK("bandwidth", 1'b1, bw_sel)
    wr(6'h18, 8'h00);
    `CHK("bandwidth", 1'b0, bw_sel)
    done("registers");
    wr(motion_detect_pkg::IDX_MODE, 8'h02);
    wr(6'h1A, 8'h10);
    src.emit(24'h000020);
    irq_is(1'b1, 1'b0);
    rchk(motion_detect_pkg::IDX_SOURCE, 8'h41);
    wr(6'h17, 8'h00);
    irq_is(1'b1, 1'b0);
    wr(6'h17, 8'h02);
    irq_is(1'b1, 1'b0);
    wr(6'h17, 8'h01);
    irq_is(1'b0, 1'b0);
    rchk(motion_detect_pkg::IDX_SOURCE, 8'h00);
    wr(6'h18, 8'h08);
    src.emit(24'h000020);
    irq_is(1'b0, 1'b0);
    src.emit(24'h002000);
    irq_is(1'b1, 1'b0);
    wr(6'h17, 8'h01);
    wr(6'h18, 8'h00);
    src.emit(24'h0000E0);
    irq_is(1'b1, 1'b0);
    wr(6'h17, 8'h01);
    wr(6'h18, 8'h40);
    src.emit(24'h0000E0);
    irq_is(1'b0, 1'b0);
    src.emit(24'h000011);
    irq_is(1'b1, 1'b0);
    wr(6'h17, 8'h01);
    wr(6'h18, 8'h00);
    wr(6'h19, 8'h01);
    src.emit(24'h002000);
    irq_is(1'b0, 1'b0);
    src.emit(24'h000000);
    irq_is(1'b1, 1'b0);
    wr(6'h17, 8'h01);
    wr(6'h19, 8'h00);
    wr(6'h18, 8'h02);
    src.emit(24'h000020);
    irq_is(1'b0, 1'b1);
    wr(6'h18, 8'h03);
    irq_is(1'b1, 1'b0);
    wr(6'h17, 8'h02);
    irq_is(1'b0, 1'b0);
    done("level");
    wr(motion_detect_pkg::IDX_MODE, 8'h03);
    wr(6'h18, 8'h00);
    wr(6'h1B, 8'h10);
    wr(6'h1C, 8'h02);
    wr(6'h1D, 8'h00);
    wr(6'h1E, 8'h00);
    src.emit(24'h000020);
    src.emit(24'h000000);
    irq_is(1'b0, 1'b1);
    wr(6'h17, 8'h02);
    src.emit(24'h000020);
    repeat (60) @(posedge clk);
    src.emit(24'h000000);
    irq_is(1'b0, 1'b0);
    wr(6'h18, 8'h04);
    src.emit(24'h000020);
    src.emit(24'h000000);
    irq_is(1'b1, 1'b1);
    done("pulse");
    // latency 2 half ticks, window 4: second start lands inside the window
    wr(6'h17, 8'h03);
    wr(6'h1D, 8'h01);
    wr(6'h1E, 8'h02);
    src.emit(24'h000020);
    src.emit(24'h000000);
    repeat (12) @(posedge clk);
    `CHK("line a", 1'b1, irq_a)
    `CHK("line b", 1'b0, irq_b)
    src.emit(24'h000020);
    src.emit(24'h000000);
    irq_is(1'b1, 1'b1);
    done("double pulse");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 23; i <= 30; i++) rchk(6'(i), 8'h00);
    `CHK("mode", 2'h0, mode)
    `CHK("line a", 1'b0, irq_a)
    `CHK("line b", 1'b0, irq_b)
    rchk(motion_detect_pkg::IDX_SOURCE, 8'h00);
    done("second reset");
    tally_and_finish();
  end
endmodule
